// *** logic/tcec_top.sv ***
// tcec_top: three independent incremental encoder counter channels
// assumes encoder pins are asynchronous and a plain register port on ref_clk
//
// Behaviour
// - each channel picks its own counting mode from its configuration register
// - mode 1 is cw/ccw, mode 3 quadrature, quadrature after reset
// - pulse/direction uses A as pulse, B as direction, B high counts up
// - each active A edge moves count by one in B's direction
// - cw/ccw counts up on A rising, down on B rising
// - quadrature counts up when A leads B, down when B leads
// - quadrature counts every edge of A and B, four per cycle
// - separate active-level settings for A, B and C applied before decoding
// - inverting A in quadrature or B in pulse/direction reverses direction
// - in cw/ccw inverting an input keeps A up and B down
// - filter passes a new value only after three equal samples
// - filter setting 0 bypasses, 1 to 8 select slower sample clocks
// - current count reported as status, refreshed at each data update
// - count clears on a rising reset request, a held request does nothing
// - reset-done flag shows the count was cleared by a request
// - count is zero after power-on without any request
// - levels of A, B and C at the last status refresh reported as status bits
// - with latch enabled each active C edge copies count into latch
// - latch edge follows the configured active level of C
// - a status bit toggles on every status refresh
// - sync-error bit shows a missed update in the previous dc cycle
`timescale 1ns/1ps
`default_nettype none
module tcec_top
#(
  parameter int DC_CYCLE_CLKS = tcec_pkg::DC_CYCLE_CLKS
)
(
  input  wire logic                             ref_clk,
  input  wire logic                             rst_n,
  input  wire logic [tcec_pkg::CHANNELS-1:0]    enc_a,
  input  wire logic [tcec_pkg::CHANNELS-1:0]    enc_b,
  input  wire logic [tcec_pkg::CHANNELS-1:0]    enc_c,
  input  wire logic [tcec_pkg::ADDR_W-1:0]      bus_addr,
  input  wire logic [tcec_pkg::DATA_W-1:0]      bus_wdata,
  input  wire logic                             bus_wr,
  input  wire logic                             bus_rd,
  output logic      [tcec_pkg::DATA_W-1:0]      bus_rdata
);
  localparam int NCH = tcec_pkg::CHANNELS;
  localparam int CW  = tcec_pkg::CNT_W;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic tcec_hit(input logic [7:0] addr, input int ch,
                                    input logic [7:0] ofs);
    tcec_hit = (addr == 8'(ch * int'(tcec_pkg::CH_STRIDE)) + ofs);
  endfunction : tcec_hit

  // filter sample tick: every 2**(setting-1) clocks
  function automatic logic tcec_tick(input logic [7:0] div, input logic [3:0] sel);
    logic [7:0] mask;
    mask = 8'hFF >> (4'h9 - sel);
    tcec_tick = ((div & mask) == mask);
  endfunction : tcec_tick

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [11:0]   cfg_reg       [NCH];
  logic [NCH-1:0] latch_en_reg;
  logic [NCH-1:0] reset_req_reg;
  logic [NCH-1:0] reset_prev_reg;
  logic [NCH-1:0] done_reg;
  logic [CW-1:0] count_reg     [NCH];
  logic [CW-1:0] latch_reg     [NCH];
  logic [CW-1:0] count_snap_reg[NCH];
  logic [CW-1:0] latch_snap_reg[NCH];
  logic [2:0]    lvl_snap_reg  [NCH];
  logic [NCH-1:0] toggle_reg;
  logic [NCH-1:0] sync_err_reg;
  logic          dc_en_reg;
  logic          missed_reg;
  logic [31:0]   dc_cnt_reg;
  logic [7:0]    div_reg;
  logic [2:0]    sync1_reg     [NCH];
  logic [2:0]    sync2_reg     [NCH];
  logic [2:0]    filt_out      [NCH];
  logic [2:0]    act_prev_reg  [NCH];
  logic [2:0]    act           [NCH];
  logic [2:0]    lvl           [NCH];
  logic          refresh;

  assign refresh = bus_wr && (bus_addr == tcec_pkg::ADDR_REFRESH);

  // ---------------------------------------------------------------
  // shared filter prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end

  // ---------------------------------------------------------------
  // per-channel datapath
  // ---------------------------------------------------------------
  genvar ch;
  genvar s;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      logic [1:0] mode;
      logic [3:0] filt_sel;
      logic [2:0] pol;
      logic       a_rise;
      logic       b_rise;
      logic       a_chg;
      logic       b_chg;
      logic       c_edge;
      logic       step_up;
      logic       step_dn;
      logic       rst_edge;

      assign mode     = cfg_reg[ch][tcec_pkg::CFG_MODE_LO +: 2];
      assign filt_sel = cfg_reg[ch][tcec_pkg::CFG_FILT_LO +: tcec_pkg::FILT_W];
      assign pol      = cfg_reg[ch][tcec_pkg::CFG_POL_C:tcec_pkg::CFG_POL_A];

      // two-flop synchroniser; first stage feeds only the second
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_reg[ch] <= 3'h0;
          sync2_reg[ch] <= 3'h0;
        end
        else
        begin
          sync1_reg[ch] <= {enc_c[ch], enc_b[ch], enc_a[ch]};
          sync2_reg[ch] <= sync1_reg[ch];
        end
      end

      for (s = 0; s < 3; s++)
      begin : g_sig
        tcec_filter u_filt
        (
          .ref_clk     (ref_clk),
          .rst_n       (rst_n),
          .bypass      (filt_sel == 4'h0),
          .sample_tick (tcec_tick(div_reg, filt_sel)),
          .din         (sync2_reg[ch][s]),
          .dout        (filt_out[ch][s])
        );
      end

      // active level: polarity bit 1 means active high
      assign act[ch] = filt_out[ch] ^ ~pol;
      assign lvl[ch] = filt_out[ch];

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          act_prev_reg[ch] <= 3'h0;
        else
          act_prev_reg[ch] <= act[ch];
      end

      assign a_rise = act[ch][0] & ~act_prev_reg[ch][0];
      assign b_rise = act[ch][1] & ~act_prev_reg[ch][1];
      assign a_chg  = act[ch][0] ^ act_prev_reg[ch][0];
      assign b_chg  = act[ch][1] ^ act_prev_reg[ch][1];
      assign c_edge = act[ch][2] & ~act_prev_reg[ch][2];

      // direction decode; polarity already folded into act
      always_comb
      begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case (mode)
          tcec_pkg::MODE_PULSE_DIR:
          begin
            step_up = a_rise & act[ch][1];
            step_dn = a_rise & ~act[ch][1];
          end
          tcec_pkg::MODE_CW_CCW:
          begin
            // simultaneous A and B rises cancel out
            step_up = a_rise & ~b_rise;
            step_dn = b_rise & ~a_rise;
          end
          tcec_pkg::MODE_QUAD:
          begin
            // both phases moving at once is a skipped state: no step
            if (a_chg && !b_chg)
            begin
              step_up = act[ch][0] != act_prev_reg[ch][1];
              step_dn = act[ch][0] == act_prev_reg[ch][1];
            end
            else if (b_chg && !a_chg)
            begin
              step_up = act[ch][1] == act_prev_reg[ch][0];
              step_dn = act[ch][1] != act_prev_reg[ch][0];
            end
          end
          default:
          begin
            step_up = 1'b0;
            step_dn = 1'b0;
          end
        endcase
      end

      assign rst_edge = reset_req_reg[ch] & ~reset_prev_reg[ch];

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          reset_prev_reg[ch] <= 1'b0;
        else
          reset_prev_reg[ch] <= reset_req_reg[ch];
      end

      // clear wins over a step in the same cycle
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          count_reg[ch] <= 32'h0000_0000;
        else if (rst_edge)
          count_reg[ch] <= 32'h0000_0000;
        else if (step_up)
          count_reg[ch] <= count_reg[ch] + 32'h0000_0001;
        else if (step_dn)
          count_reg[ch] <= count_reg[ch] - 32'h0000_0001;
      end

      // done stays up while the request stays true
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          done_reg[ch] <= 1'b0;
        else if (rst_edge)
          done_reg[ch] <= 1'b1;
        else if (!reset_req_reg[ch])
          done_reg[ch] <= 1'b0;
      end

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          latch_reg[ch] <= 32'h0000_0000;
        else if (latch_en_reg[ch] && c_edge)
          latch_reg[ch] <= count_reg[ch];
      end

      // status image, refreshed per process-data update
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          count_snap_reg[ch] <= 32'h0000_0000;
          latch_snap_reg[ch] <= 32'h0000_0000;
          lvl_snap_reg[ch]   <= 3'h0;
          toggle_reg[ch]     <= 1'b0;
          sync_err_reg[ch]   <= 1'b0;
        end
        else if (refresh)
        begin
          count_snap_reg[ch] <= count_reg[ch];
          latch_snap_reg[ch] <= latch_reg[ch];
          lvl_snap_reg[ch]   <= lvl[ch];
          toggle_reg[ch]     <= ~toggle_reg[ch];
          sync_err_reg[ch]   <= dc_en_reg & missed_reg;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // distributed-clock update watchdog
  // ---------------------------------------------------------------
  // the master owes one refresh per interval; a miss is held
  // until the next refresh reports it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      dc_cnt_reg <= 32'h0000_0000;
    else if (refresh || !dc_en_reg)
      dc_cnt_reg <= 32'h0000_0000;
    else if (dc_cnt_reg != 32'(DC_CYCLE_CLKS))
      dc_cnt_reg <= dc_cnt_reg + 32'h0000_0001;
  end

  // timeout in the refresh cycle still counts: set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      missed_reg <= 1'b0;
    else if (dc_en_reg && dc_cnt_reg == 32'(DC_CYCLE_CLKS - 1))
      missed_reg <= 1'b1;
    else if (refresh || !dc_en_reg)
      missed_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NCH; i++)
        cfg_reg[i] <= tcec_pkg::CFG_RESET;
      latch_en_reg  <= '0;
      reset_req_reg <= '0;
      dc_en_reg     <= 1'b0;
    end
    else if (bus_wr)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (tcec_hit(bus_addr, i, tcec_pkg::OFS_CFG))
        begin
          cfg_reg[i][2:0] <= bus_wdata[2:0];
          cfg_reg[i][tcec_pkg::CFG_MODE_LO +: 2] <=
            bus_wdata[tcec_pkg::CFG_MODE_LO +: 2];
          // out-of-range filter settings clamp to the slowest
          if (bus_wdata[tcec_pkg::CFG_FILT_LO +: 4] > tcec_pkg::FILT_MAX)
            cfg_reg[i][tcec_pkg::CFG_FILT_LO +: 4] <= tcec_pkg::FILT_MAX;
          else
            cfg_reg[i][tcec_pkg::CFG_FILT_LO +: 4] <=
              bus_wdata[tcec_pkg::CFG_FILT_LO +: 4];
        end
        if (tcec_hit(bus_addr, i, tcec_pkg::OFS_CTRL))
        begin
          latch_en_reg[i]  <= bus_wdata[tcec_pkg::CTRL_LATCH_EN];
          reset_req_reg[i] <= bus_wdata[tcec_pkg::CTRL_RESET];
        end
      end
      if (bus_addr == tcec_pkg::ADDR_SYS)
        dc_en_reg <= bus_wdata[tcec_pkg::SYS_DC_EN];
    end
  end

  // ---------------------------------------------------------------
  // register reads: data only in the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_rdata <= 32'h0000_0000;
    else
    begin
      bus_rdata <= 32'h0000_0000;
      if (bus_rd)
      begin
        for (int i = 0; i < NCH; i++)
        begin
          if (tcec_hit(bus_addr, i, tcec_pkg::OFS_CFG))
            bus_rdata <= {20'h0_0000, cfg_reg[i]};
          if (tcec_hit(bus_addr, i, tcec_pkg::OFS_CTRL))
            bus_rdata <= {29'h0000_0000, reset_req_reg[i], 1'b0, latch_en_reg[i]};
          if (tcec_hit(bus_addr, i, tcec_pkg::OFS_STAT))
            bus_rdata <= {16'h0000, toggle_reg[i], sync_err_reg[i], 9'h000,
                          lvl_snap_reg[i], 1'b0, done_reg[i]};
          if (tcec_hit(bus_addr, i, tcec_pkg::OFS_COUNT))
            bus_rdata <= count_snap_reg[i];
          if (tcec_hit(bus_addr, i, tcec_pkg::OFS_LATCH))
            bus_rdata <= latch_snap_reg[i];
        end
        if (bus_addr == tcec_pkg::ADDR_SYS)
          bus_rdata <= {31'h0000_0000, dc_en_reg};
      end
    end
  end
endmodule : tcec_top
`default_nettype wire

// *** logic/tcec_pkg.sv ***
// tcec_pkg: constants shared by the three-channel encoder counter
// assumes word-aligned byte addresses on the plain register port
package tcec_pkg;
  localparam int          CHANNELS       = 3;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          CNT_W          = 32;
  localparam int          FILT_W         = 4;

  // ---------------------------------------------------------------
  // register map, per-channel window of CH_STRIDE bytes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CH_STRIDE      = 8'h20;
  localparam logic [7:0]  OFS_CFG        = 8'h00;
  localparam logic [7:0]  OFS_CTRL       = 8'h04;
  localparam logic [7:0]  OFS_STAT       = 8'h08;
  localparam logic [7:0]  OFS_COUNT      = 8'h0C;
  localparam logic [7:0]  OFS_LATCH      = 8'h10;
  localparam logic [7:0]  ADDR_SYS       = 8'h60;
  localparam logic [7:0]  ADDR_REFRESH   = 8'h64;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          CFG_POL_A      = 0;
  localparam int          CFG_POL_B      = 1;
  localparam int          CFG_POL_C      = 2;
  localparam int          CFG_MODE_LO    = 4;
  localparam int          CFG_FILT_LO    = 8;
  localparam int          CTRL_LATCH_EN  = 0;
  localparam int          CTRL_RESET     = 2;
  localparam int          ST_DONE        = 0;
  localparam int          ST_LVL_A       = 2;
  localparam int          ST_LVL_B       = 3;
  localparam int          ST_LVL_C       = 4;
  localparam int          ST_SYNC_ERR    = 14;
  localparam int          ST_TOGGLE      = 15;
  localparam int          SYS_DC_EN      = 0;

  // ---------------------------------------------------------------
  // mode encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_PULSE_DIR = 2'h0;
  localparam logic [1:0]  MODE_CW_CCW    = 2'h1;
  localparam logic [1:0]  MODE_QUAD      = 2'h3;
  localparam logic [11:0] CFG_RESET      = 12'h037;
  localparam logic [3:0]  FILT_MAX       = 4'h8;

  // ---------------------------------------------------------------
  // timing: distributed-clock update interval
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          DC_CYCLE_NS    = 1000000;
  localparam int          DC_CYCLE_CLKS  = DC_CYCLE_NS / CLK_PERIOD_NS;
endpackage : tcec_pkg

// *** logic/tcec_filter.sv ***
// tcec_filter: three-sample agreement noise filter for one input
// assumes input already synchronised to ref_clk
`timescale 1ns/1ps
`default_nettype none
module tcec_filter
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic bypass,
  input  wire logic sample_tick,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] samp_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      samp_reg <= 3'h0;
    else if (sample_tick)
      samp_reg <= {samp_reg[1:0], din};
  end

  // outside bypass, output moves only on three equal samples, otherwise holds
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      dout <= 1'b0;
    else if (bypass)
      dout <= din;
    else if (samp_reg == 3'h7)
      dout <= 1'b1;
    else if (samp_reg == 3'h0)
      dout <= 1'b0;
  end
endmodule : tcec_filter
`default_nettype wire

// *** dv/tcec_top_assertions.sv ***
// tcec_top_assertions: port-level checker for the encoder counter block
// assumes one clock domain and a bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module tcec_checker
(
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic [tcec_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [tcec_pkg::DATA_W-1:0] bus_wdata,
  input  wire logic                        bus_wr,
  input  wire logic                        bus_rd,
  input  wire logic [tcec_pkg::DATA_W-1:0] bus_rdata
);
  logic seen_ref;
  logic dc_ever;
  logic lat2_en;
  logic tgl;

  // history of software writes that the read-side checks depend on
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seen_ref <= 1'b0;
      dc_ever  <= 1'b0;
      lat2_en  <= 1'b0;
      tgl      <= 1'b0;
    end
    else if (bus_wr && bus_addr == tcec_pkg::ADDR_REFRESH)
    begin
      seen_ref <= 1'b1;
      tgl      <= ~tgl;
    end
    else if (bus_wr && bus_addr == tcec_pkg::ADDR_SYS && bus_wdata[0])
      dc_ever <= 1'b1;
    else if (bus_wr && bus_addr == 8'h44 && bus_wdata[0])
      lat2_en <= 1'b1;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == '0)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (bus_rd && bus_addr == 8'h7C |=> bus_rdata == '0)
    else $error("unmapped read returned data");
  a_count_power_zero: assert property (bus_rd && bus_addr == 8'h0C && !seen_ref |=>
    bus_rdata == '0)
    else $error("count not zero after power-on");
  a_latch_idle_zero: assert property (bus_rd && bus_addr == 8'h50 && !lat2_en |=>
    bus_rdata == '0)
    else $error("latch changed while capture disabled");
  a_toggle_follows: assert property (bus_rd && bus_addr == 8'h08 |=> bus_rdata[15] == tgl)
    else $error("toggle bit does not follow refreshes");
  a_sync_quiet: assert property (bus_rd && bus_addr == 8'h08 && !dc_ever |=>
    !bus_rdata[14])
    else $error("sync error without dc mode");
  a_stat_reserved: assert property (bus_rd && bus_addr == 8'h28 |=>
    bus_rdata[31:16] == '0 && bus_rdata[13:5] == '0 && !bus_rdata[1])
    else $error("status reserved bits set");
  a_cfg_readback: assert property (bus_wr && bus_addr == 8'h00 && bus_wdata[11:8] <= 4'h8
    ##1 bus_rd && bus_addr == 8'h00 |=> bus_rdata == ($past(bus_wdata, 2) & 32'h0000_0F37))
    else $error("configuration readback differs");
endmodule : tcec_checker
`default_nettype wire

// *** dv/tcec_enc_model.sv ***
// tcec_enc_model: behavioural incremental encoder on channel pins
// assumes the bench calls its tasks; pins change just after ref_clk rises
`timescale 1ns/1ps
`default_nettype none
module tcec_enc_model
(
  input  wire logic       ref_clk,
  output logic      [2:0] enc_a,
  output logic      [2:0] enc_b,
  output logic      [2:0] enc_c
);
  // {a,b} pairs per unit: fwd, back, a pulses, b pulses, a with b high, glitch
  localparam logic [7:0] SEQ [6] = '{8'hB4, 8'h78, 8'h88, 8'h44, 8'h77, 8'h88};

  initial
  begin
    enc_a = '0;
    enc_b = '0;
    enc_c = '0;
  end

  // six cycles per level outruns filter settings 0 and 1; two is a glitch
  task automatic put(input int ch, input logic [2:0] abc, input int k);
    @(posedge ref_clk);
    enc_a[ch] <= abc[2];
    enc_b[ch] <= abc[1];
    enc_c[ch] <= abc[0];
    repeat (k - 1) @(posedge ref_clk);
  endtask : put

  task automatic move(input int ch, input int pat, input int n);
    logic [7:0] s;
    s = SEQ[pat];
    for (int i = 0; i < 4 * n; i++)
      put(ch, {s[7 - 2 * (i % 4)], s[6 - 2 * (i % 4)], 1'b0}, (pat == 5) ? 2 : 6);
    put(ch, 3'b000, 6);
  endtask : move
endmodule : tcec_enc_model
`default_nettype wire

// *** dv/tcec_top_tb.sv ***
// tcec_top_tb: self-checking bench for the three-channel encoder counter
// assumes the encoder model owns the pins and the bench owns the register port
`timescale 1ns/1ps
`default_nettype none
module tcec_top_tb;
  typedef struct packed
  {
    logic [11:0] cfg;
    logic [2:0]  pat;
    logic [1:0]  n;
    logic [31:0] exp;
  } tcec_row_type;

  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [2:0]  enc_a;
  logic [2:0]  enc_b;
  logic [2:0]  enc_c;
  logic [7:0]  bus_addr  = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr    = 1'b0;
  logic        bus_rd    = 1'b0;
  logic [31:0] bus_rdata;
  logic [31:0] q;
  int          bad_count = 0;
  int          n_tests   = 0;

  // count expected on channel 0 after one motion from a cleared count
  tcec_row_type rows [11] = '{
    '{12'h037, 3'h0, 2'h2, 32'h0000_0008},
    '{12'h036, 3'h0, 2'h2, 32'hFFFF_FFF8},
    '{12'h037, 3'h1, 2'h1, 32'hFFFF_FFFC},
    '{12'h017, 3'h2, 2'h2, 32'h0000_0004},
    '{12'h014, 3'h2, 2'h2, 32'h0000_0004},
    '{12'h017, 3'h3, 2'h1, 32'hFFFF_FFFE},
    '{12'h007, 3'h4, 2'h1, 32'h0000_0002},
    '{12'h005, 3'h4, 2'h1, 32'hFFFF_FFFE},
    '{12'h027, 3'h0, 2'h1, 32'h0000_0000},
    '{12'h117, 3'h5, 2'h2, 32'h0000_0000},
    '{12'h117, 3'h2, 2'h1, 32'h0000_0002}
  };

  always #25 ref_clk = ~ref_clk;

  tcec_top #(.DC_CYCLE_CLKS(50)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .enc_a(enc_a),
    .enc_b(enc_b), .enc_c(enc_c), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  tcec_enc_model u_enc (.ref_clk(ref_clk), .enc_a(enc_a), .enc_b(enc_b), .enc_c(enc_c));

  // ----------------------------------------
  // register port and reporting
  // ----------------------------------------
  task automatic drive(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d);
    @(posedge ref_clk);
    bus_wr    <= w;
    bus_rd    <= r;
    bus_addr  <= a;
    bus_wdata <= d;
  endtask : drive

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    drive(1'b1, 1'b0, a, d);
    drive(1'b0, 1'b0, a, d);
  endtask : wr

  // answer stands only in the cycle after the strobe, so take it mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    drive(1'b0, 1'b1, a, 32'h0);
    drive(1'b0, 1'b0, a, 32'h0);
    @(negedge ref_clk);
    d = bus_rdata;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h0C, q);
    chk(q, 32'h0);
    for (int c = 0; c < 3; c++)
    begin
      rd(8'(c * 32), q);
      chk(q, 32'h37);
    end
    rd(8'h7C, q);
    chk(q, 32'h0);
    rd(8'h50, q);
    chk(q, 32'h0);
    $display("reset values done");
    foreach (rows[i])
    begin
      drive(1'b1, 1'b0, 8'h00, {20'h0, rows[i].cfg});
      rd(8'h00, q);
      chk(q, {20'h0, rows[i].cfg});
      // a polarity change can fake an edge; let it settle before clearing
      repeat (8) @(posedge ref_clk);
      wr(8'h04, 32'h0);
      wr(8'h04, 32'h4);
      rd(8'h08, q);
      chk({31'h0, q[0]}, 32'h1);
      u_enc.move(0, rows[i].pat, rows[i].n);
      wr(8'h64, 32'h0);
      rd(8'h0C, q);
      chk(q, rows[i].exp);
      $display("row %0d done", i);
    end
    wr(8'h04, 32'h4);
    wr(8'h64, 32'h0);
    rd(8'h0C, q);
    chk(q, 32'h2);
    wr(8'h00, 32'hF37);
    rd(8'h00, q);
    chk(q, 32'h837);
    wr(8'h00, 32'h37);
    repeat (8) @(posedge ref_clk);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h5);
    u_enc.move(0, 0, 1);
    u_enc.put(0, 3'b001, 6);
    u_enc.put(0, 3'b000, 6);
    u_enc.move(0, 0, 1);
    wr(8'h04, 32'h4);
    u_enc.put(0, 3'b001, 6);
    u_enc.put(0, 3'b000, 6);
    wr(8'h64, 32'h0);
    rd(8'h10, q);
    chk(q, 32'h4);
    // index active low: capture on the falling pin, a rising pin must not capture
    wr(8'h00, 32'h33);
    wr(8'h04, 32'h5);
    u_enc.put(0, 3'b001, 6);
    u_enc.put(0, 3'b000, 6);
    u_enc.move(0, 0, 1);
    u_enc.put(0, 3'b001, 6);
    wr(8'h04, 32'h4);
    u_enc.put(0, 3'b000, 6);
    wr(8'h64, 32'h0);
    rd(8'h10, q);
    chk(q, 32'h8);
    u_enc.put(1, 3'b101, 6);
    wr(8'h64, 32'h0);
    rd(8'h28, q);
    chk({29'h0, q[4:2]}, 32'h5);
    u_enc.put(1, 3'b000, 6);
    $display("held reset, latch and levels done");
    wr(8'h60, 32'h1);
    repeat (60) @(posedge ref_clk);
    wr(8'h64, 32'h0);
    rd(8'h08, q);
    chk({31'h0, q[14]}, 32'h1);
    wr(8'h64, 32'h0);
    rd(8'h08, q);
    chk({31'h0, q[14]}, 32'h0);
    wr(8'h60, 32'h0);
    $display("sync error done");
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("wrong value at %0t: run hung", $time);
    wrap_up();
  end
endmodule : tcec_top_tb

bind tcec_top tcec_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
`default_nettype wire
